//--- hw/scm_defs.svh
// Constants for the system clock and operating-mode controller.
// Assumes APB byte addresses of 12 bits and a 40 MHz register clock.
`ifndef SCM_DEFS_SVH
`define SCM_DEFS_SVH

// Register byte offsets
`define SCM_OFS_CONTROL_REG_ZERO   12'h000
`define SCM_OFS_CONTROL_REG_TWO   12'h004
`define SCM_OFS_STATUS  12'h008
`define SCM_OFS_MODE    12'h00C

// Field positions
`define SCM_SLOW_SEL_BIT 0
`define SCM_PWR_MODE_BIT 1
`define SCM_KEEP_ON_BIT  0
`define SCM_PDF_BIT      0
`define SCM_WTO_BIT      1

// Reset values
`define SCM_CONTROL_REG_ZERO_RST    2'h0
`define SCM_CONTROL_REG_TWO_RST    1'h1

// Dead time between one clock gate closing and the other opening
`define SCM_GAP_CYCLES   3'h2

// Internal fast RC frequency codes
`define SCM_IRC_4MHZ     2'h0
`define SCM_IRC_8MHZ     2'h1
`define SCM_IRC_12MHZ    2'h2

`endif

//--- hw/scm_pkg.sv
// Types of the system clock and operating-mode controller.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package scm_pkg;

    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_SLOW   = 2'b01,
        MODE_IDLE   = 2'b10,
        MODE_SLEEP  = 2'b11
    } scm_mode_t;

    typedef enum logic [1:0] {
        FAST_XTAL = 2'b00,
        FAST_ERC  = 2'b01,
        FAST_IRC  = 2'b10
    } scm_fast_t;

    typedef enum logic [1:0] {
        WSRC_SLOWRC = 2'b00,
        WSRC_SLOWXT = 2'b01,
        WSRC_SYS    = 2'b10
    } scm_wsrc_t;

    typedef enum logic [1:0] {
        SW_FAST = 2'b00,
        SW_GAP  = 2'b01,
        SW_SLOW = 2'b10,
        SW_OFF  = 2'b11
    } scm_sw_t;

    // Configuration straps, static after reset
    typedef struct packed {
        scm_fast_t  fastSel;
        logic [1:0] ircFreq;
        logic       slowXtalCfg;
        logic       slowRcCfg;
        scm_wsrc_t  wdtSrc;
    } scm_cfg_t;

endpackage : scm_pkg

`default_nettype wire

//--- hw/scm_clk_switch.sv
// Break-before-make gate control for the fast and slow system clocks.
// Assumes wantSlow and stopAll come from flops on the same clock.
`include "scm_defs.svh"
`default_nettype none

module scm_clk_switch (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic wantSlow,
    input  wire logic stopAll,
    output var  logic fastGate,
    output var  logic slowGate
);

    scm_pkg::scm_sw_t state;
    logic [2:0]       gapCnt;

    // Close the open gate, wait out the gap, then open the other one
    always_ff @(posedge clk) begin
        if (srst) begin
            state    <= scm_pkg::SW_FAST;
            fastGate <= 1'b1;
            slowGate <= 1'b0;
            gapCnt   <= 3'h0;
        end else begin
            case (state)
                scm_pkg::SW_FAST: begin
                    if (stopAll || wantSlow) begin
                        state    <= scm_pkg::SW_GAP;
                        fastGate <= 1'b0;
                        gapCnt   <= 3'h0;
                    end
                end
                scm_pkg::SW_SLOW: begin
                    if (stopAll || !wantSlow) begin
                        state    <= scm_pkg::SW_GAP;
                        slowGate <= 1'b0;
                        gapCnt   <= 3'h0;
                    end
                end
                scm_pkg::SW_OFF: begin
                    if (!stopAll) begin
                        state  <= scm_pkg::SW_GAP;
                        gapCnt <= 3'h0;
                    end
                end
                scm_pkg::SW_GAP: begin
                    gapCnt <= gapCnt + 3'h1;
                    if (gapCnt == `SCM_GAP_CYCLES - 3'h1) begin
                        if (stopAll) begin
                            state <= scm_pkg::SW_OFF;
                        end else if (wantSlow) begin
                            state    <= scm_pkg::SW_SLOW;
                            slowGate <= 1'b1;
                        end else begin
                            state    <= scm_pkg::SW_FAST;
                            fastGate <= 1'b1;
                        end
                    end
                end
                default: begin
                    state    <= scm_pkg::SW_FAST;
                    fastGate <= 1'b1;
                    slowGate <= 1'b0;
                end
            endcase
        end
    end

    gate_exclusive_a: assert property (@(posedge clk) disable iff (srst)
        !(fastGate && slowGate))
        else $error("both clock gates open");

    gate_deadtime_a: assert property (@(posedge clk) disable iff (srst)
        ($rose(fastGate) || $rose(slowGate)) |->
            $past(!fastGate && !slowGate, 2))
        else $error("clock gate opened without dead time");

endmodule : scm_clk_switch

`default_nettype wire

//--- hw/scm_mode_ctrl.sv
// System clock source and operating-mode controller with APB registers.
// Assumes core strobes on clk; wake pin and straps are asynchronous.
`include "scm_defs.svh"
`default_nettype none

module scm_mode_ctrl (
    input  wire logic              clk,
    input  wire logic              srst,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output var  logic [31:0]       prdata,
    output var  logic              pready,
    output var  logic              pslverr,
    // Core and watchdog events
    input  wire logic              haltReq,
    input  wire logic              irqWake,
    input  wire logic              wdtTimeout,
    input  wire logic              clrWdtReq,
    input  wire logic              wakePin,
    input  wire scm_pkg::scm_cfg_t cfgPins,
    // Oscillator and clock controls
    output var  logic              fastOscEn,
    output var  logic [1:0]        ircFreqSel,
    output var  logic              sharedPinsGpio,
    output var  logic              slowXtalRun,
    output var  logic              slowXtalLowPower,
    output var  logic              slowRcRun,
    output var  logic              fastClkGate,
    output var  logic              slowClkGate,
    output var  logic              periphSlowClkOk,
    output var  logic              cpuHold,
    output var  logic              wdtRun,
    output var  logic              wdtClear,
    output var  logic              powerDownFlag,
    output var  logic              watchdogExpiredFlag
);

    scm_pkg::scm_cfg_t cfgSync1;
    scm_pkg::scm_cfg_t cfgSync2;
    scm_pkg::scm_cfg_t cfg;
    logic              cfgArmed;
    logic              wakeSync1;
    logic              wakeSync2;

    scm_pkg::scm_mode_t mode;
    scm_pkg::scm_mode_t next_mode;
    scm_pkg::scm_mode_t haltTarget;
    scm_pkg::scm_mode_t runTarget;

    logic slowClockSelect;
    logic slowCrystalPowerMode;
    logic keepSlowCrystalOn;
    logic slowSelEff;
    logic running;
    logic haltEntry;
    logic sleepEntry;
    logic wakeEvt;
    logic apbAccess;
    logic wrEn;
    logic addrOk;
    logic [31:0] rdMux;

    // Two-flop synchronisers; free-running so straps settle during reset
    always_ff @(posedge clk) begin
        cfgSync1  <= cfgPins;
        cfgSync2  <= cfgSync1;
        wakeSync1 <= wakePin;
        wakeSync2 <= wakeSync1;
    end

    // Straps caught once after reset; later pin changes are ignored
    always_ff @(posedge clk) begin
        if (srst) begin
            cfg      <= '0;
            cfgArmed <= 1'b1;
        end else if (cfgArmed) begin
            cfg      <= cfgSync2;
            cfgArmed <= 1'b0;
        end
    end

    // Slow selection needs the strap, otherwise the crystal is absent
    assign slowSelEff = slowClockSelect & cfg.slowXtalCfg;
    assign running    = (mode == scm_pkg::MODE_NORMAL) ||
                        (mode == scm_pkg::MODE_SLOW);
    assign haltEntry  = haltReq & running;
    assign wakeEvt    = wakeSync2 | irqWake | wdtTimeout;

    // Halt target depends on keep-on and the crystal strap, never on the select bit
    always_comb begin
        if (keepSlowCrystalOn && cfg.slowXtalCfg) begin
            haltTarget = scm_pkg::MODE_IDLE;
        end else begin
            haltTarget = scm_pkg::MODE_SLEEP;
        end
        if (slowSelEff) begin
            runTarget = scm_pkg::MODE_SLOW;
        end else begin
            runTarget = scm_pkg::MODE_NORMAL;
        end
    end

    assign sleepEntry = haltEntry && (haltTarget == scm_pkg::MODE_SLEEP);

    // Operating mode transitions
    always_comb begin
        next_mode = mode;
        case (mode)
            scm_pkg::MODE_NORMAL,
            scm_pkg::MODE_SLOW: begin
                if (haltReq) begin
                    next_mode = haltTarget;
                end else begin
                    next_mode = runTarget;
                end
            end
            scm_pkg::MODE_IDLE,
            scm_pkg::MODE_SLEEP: begin
                if (wakeEvt) begin
                    next_mode = runTarget;
                end
            end
            default: begin
                next_mode = scm_pkg::MODE_NORMAL;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            mode <= scm_pkg::MODE_NORMAL;
        end else begin
            mode <= next_mode;
        end
    end

    // Oscillator enables follow the mode being entered; the slow RC enable follows its strap only
    always_ff @(posedge clk) begin
        if (srst) begin
            fastOscEn       <= 1'b1;
            slowXtalRun     <= 1'b0;
            slowRcRun       <= 1'b0;
            periphSlowClkOk <= 1'b0;
            cpuHold         <= 1'b0;
        end else begin
            // Fast oscillator runs only in Normal mode
            fastOscEn   <= (next_mode == scm_pkg::MODE_NORMAL);
            // Slow crystal runs beside any fast source, stops in Sleep
            slowXtalRun <= cfg.slowXtalCfg &&
                           (next_mode != scm_pkg::MODE_SLEEP);
            // Low-power bit deliberately not in this term
            periphSlowClkOk <= cfg.slowXtalCfg &&
                               (next_mode != scm_pkg::MODE_SLEEP);
            slowRcRun   <= cfg.slowRcCfg;
            // Core held at the halt; its memory and ports keep state
            cpuHold     <= (next_mode == scm_pkg::MODE_IDLE) ||
                           (next_mode == scm_pkg::MODE_SLEEP);
        end
    end

    // Fast source selection follows the straps
    always_ff @(posedge clk) begin
        if (srst) begin
            sharedPinsGpio <= 1'b0;
            ircFreqSel     <= `SCM_IRC_4MHZ;
        end else begin
            sharedPinsGpio <= (cfg.fastSel == scm_pkg::FAST_IRC);
            // Unused code falls back to the lowest frequency
            if (cfg.ircFreq == `SCM_IRC_8MHZ ||
                cfg.ircFreq == `SCM_IRC_12MHZ) begin
                ircFreqSel <= cfg.ircFreq;
            end else begin
                ircFreqSel <= `SCM_IRC_4MHZ;
            end
        end
    end

    // Glitch-free gating of the core clock
    scm_clk_switch u_switch (
        .clk      (clk),
        .srst     (srst),
        .wantSlow (mode == scm_pkg::MODE_SLOW),
        .stopAll  (!running),
        .fastGate (fastClkGate),
        .slowGate (slowClkGate)
    );

    // Watchdog clock: system-derived source dies with the core clock
    always_ff @(posedge clk) begin
        if (srst) begin
            wdtRun   <= 1'b1;
            wdtClear <= 1'b0;
        end else begin
            wdtClear <= sleepEntry &&
                        (cfg.wdtSrc == scm_pkg::WSRC_SLOWRC);
            if (next_mode == scm_pkg::MODE_NORMAL ||
                next_mode == scm_pkg::MODE_SLOW) begin
                wdtRun <= 1'b1;
            end else if (cfg.wdtSrc == scm_pkg::WSRC_SLOWRC) begin
                wdtRun <= cfg.slowRcCfg;
            end else if (cfg.wdtSrc == scm_pkg::WSRC_SLOWXT) begin
                wdtRun <= (next_mode == scm_pkg::MODE_IDLE);
            end else begin
                wdtRun <= 1'b0;
            end
        end
    end

    // Status flags; a setting event beats a clear in the same cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            powerDownFlag       <= 1'b0;
            watchdogExpiredFlag <= 1'b0;
        end else begin
            if (haltEntry) begin
                powerDownFlag <= 1'b1;
            end else if (clrWdtReq) begin
                powerDownFlag <= 1'b0;
            end
            if (wdtTimeout) begin
                watchdogExpiredFlag <= 1'b1;
            end else if (sleepEntry) begin
                watchdogExpiredFlag <= 1'b0;
            end
        end
    end

    // APB decode: one wait state, then pready for a single cycle
    assign apbAccess = psel && penable;
    assign wrEn      = apbAccess && pwrite && pready;
    assign addrOk    = (paddr == `SCM_OFS_CONTROL_REG_ZERO)  ||
                       (paddr == `SCM_OFS_CONTROL_REG_TWO)  ||
                       (paddr == `SCM_OFS_STATUS) ||
                       (paddr == `SCM_OFS_MODE);

    // Control registers, written at the completing edge only
    always_ff @(posedge clk) begin
        if (srst) begin
            slowClockSelect      <= 1'(`SCM_CONTROL_REG_ZERO_RST >> `SCM_SLOW_SEL_BIT);
            slowCrystalPowerMode <= 1'b0;
            keepSlowCrystalOn    <= `SCM_CONTROL_REG_TWO_RST;
        end else if (wrEn && paddr == `SCM_OFS_CONTROL_REG_ZERO) begin
            slowClockSelect      <= pwdata[`SCM_SLOW_SEL_BIT];
            slowCrystalPowerMode <= pwdata[`SCM_PWR_MODE_BIT];
        end else if (wrEn && paddr == `SCM_OFS_CONTROL_REG_TWO) begin
            keepSlowCrystalOn    <= pwdata[`SCM_KEEP_ON_BIT];
        end
    end

    // Power-mode bit only trims bias current
    always_ff @(posedge clk) begin
        if (srst) begin
            slowXtalLowPower <= 1'b0;
        end else begin
            slowXtalLowPower <= slowCrystalPowerMode;
        end
    end

    // Read data mux
    always_comb begin
        rdMux = 32'h0000_0000;
        case (paddr)
            `SCM_OFS_CONTROL_REG_ZERO: begin
                rdMux[`SCM_SLOW_SEL_BIT] = slowClockSelect;
                rdMux[`SCM_PWR_MODE_BIT] = slowCrystalPowerMode;
            end
            `SCM_OFS_CONTROL_REG_TWO: begin
                rdMux[`SCM_KEEP_ON_BIT] = keepSlowCrystalOn;
            end
            `SCM_OFS_STATUS: begin
                rdMux[`SCM_PDF_BIT] = powerDownFlag;
                rdMux[`SCM_WTO_BIT] = watchdogExpiredFlag;
            end
            `SCM_OFS_MODE: begin
                rdMux[1:0] = mode;
                rdMux[2]   = fastClkGate;
                rdMux[3]   = slowClkGate;
                rdMux[4]   = slowXtalRun;
            end
            default: begin
                rdMux = 32'h0000_0000;
            end
        endcase
    end

    // Answer flops; reads sample data one edge before completion
    always_ff @(posedge clk) begin
        if (srst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= apbAccess && !pready;
            pslverr <= apbAccess && !pready && !addrOk;
            if (apbAccess && !pready) begin
                prdata <= rdMux;
            end
        end
    end

    default clocking dc @(posedge clk); endclocking
    default disable iff (srst);

    halt_idle_a: assert property (
        haltEntry && keepSlowCrystalOn && cfg.slowXtalCfg
            |=> mode == scm_pkg::MODE_IDLE && cpuHold)
        else $error("halt with keep-on did not reach Idle");

    halt_sleep_a: assert property (
        haltEntry && !(keepSlowCrystalOn && cfg.slowXtalCfg)
            |=> mode == scm_pkg::MODE_SLEEP && !slowXtalRun)
        else $error("halt without keep-on did not reach Sleep");

    halt_indep_a: assert property (
        haltEntry |=> !running ##1 $past(powerDownFlag))
        else $error("halt ignored in some select state");

    fast_stop_a: assert property (
        $rose(cpuHold) |-> !fastOscEn ##[1:4] !fastClkGate)
        else $error("fast clock still running while halted");

    slow_cfg_a: assert property (
        mode == scm_pkg::MODE_SLOW |-> cfg.slowXtalCfg)
        else $error("Slow mode entered without strap");

    select_slow_a: assert property (
        running && !haltReq && slowSelEff
            |=> mode == scm_pkg::MODE_SLOW && !fastOscEn)
        else $error("select bit did not give Slow mode");

    sleep_flags_a: assert property (
        sleepEntry && !wdtTimeout
            |=> powerDownFlag && !watchdogExpiredFlag)
        else $error("Sleep entry flags wrong");

    wdt_clear_a: assert property (
        sleepEntry && cfg.wdtSrc == scm_pkg::WSRC_SLOWRC
            |=> wdtClear ##1 !wdtClear)
        else $error("watchdog clear pulse missing on Sleep");

    power_mode_a: assert property (
        $fell(srst) |-> !slowXtalLowPower)
        else $error("power-mode not cleared by reset");

    gpio_pins_a: assert property (
        !cfgArmed |=> sharedPinsGpio ==
            ($past(cfg.fastSel) == scm_pkg::FAST_IRC))
        else $error("shared pins not released for internal RC");

    slow_rc_a: assert property (
        !cfgArmed |=> slowRcRun == $past(cfg.slowRcCfg))
        else $error("slow RC enable does not follow strap");

endmodule : scm_mode_ctrl

`default_nettype wire

//--- tb/system_clock_mode_control_test.sv
// Self-checking bench for the clock and operating-mode controller.
// Assumes scm_pkg and scm_defs.svh are compiled; straps are held fixed.
`include "scm_defs.svh"
`default_nettype none

module system_clock_mode_control_test;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk = 1'b0, srst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err;
    logic        haltReq = 1'b0, irqWake = 1'b0, wdtTimeout = 1'b0;
    logic        clrWdtReq = 1'b0, clrSeen;
    logic        fastOscEn, sharedPinsGpio, slowXtalRun, slowXtalLowPower;
    logic        slowRcRun, fastClkGate, slowClkGate, periphSlowClkOk;
    logic        cpuHold, wdtRun, wdtClear, powerDownFlag;
    logic        watchdogExpiredFlag;
    logic [1:0]  ircFreqSel;
    int          fail_count = 0, comparisons = 0;
    // Straps: internal fast RC at 12 MHz, both slow sources on
    scm_pkg::scm_cfg_t cfg = '{fastSel: scm_pkg::FAST_IRC, ircFreq: 2'h2,
        slowXtalCfg: 1'b1, slowRcCfg: 1'b1, wdtSrc: scm_pkg::WSRC_SLOWRC};

    always #12.5 clk = ~clk;

    scm_mode_ctrl dut_u (.clk(clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .haltReq(haltReq), .irqWake(irqWake), .wdtTimeout(wdtTimeout),
        .clrWdtReq(clrWdtReq), .wakePin(1'b0), .cfgPins(cfg),
        .fastOscEn(fastOscEn), .ircFreqSel(ircFreqSel),
        .sharedPinsGpio(sharedPinsGpio), .slowXtalRun(slowXtalRun),
        .slowXtalLowPower(slowXtalLowPower), .slowRcRun(slowRcRun),
        .fastClkGate(fastClkGate), .slowClkGate(slowClkGate),
        .periphSlowClkOk(periphSlowClkOk), .cpuHold(cpuHold),
        .wdtRun(wdtRun), .wdtClear(wdtClear), .powerDownFlag(powerDownFlag),
        .watchdogExpiredFlag(watchdogExpiredFlag));

    task automatic close_out();
        $display("checks %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer; held until pready is sampled high at an edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            fail_count++;
            close_out();
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd, e);
    endtask : rd_chk

    // Gates settle after a dead time; bounded wait
    task automatic wait_gate(input logic f, input logic s);
        int n;
        for (n = 0; n < 20 && {fastClkGate, slowClkGate} !== {f, s}; n++)
            @(negedge clk);
        check({fastClkGate, slowClkGate}, {f, s});
        if (n == 20) begin
            close_out();
        end
    endtask : wait_gate

    // Halt pulse; wdtClear may answer at the halt edge or one later
    task automatic halt();
        @(posedge clk) haltReq <= 1'b1;
        @(posedge clk) haltReq <= 1'b0;
        #1 clrSeen = wdtClear;
        @(posedge clk) #1 clrSeen |= wdtClear;
    endtask : halt

    task automatic wake();
        @(posedge clk) irqWake <= 1'b1;
        @(posedge clk) irqWake <= 1'b0;
        #1;
    endtask : wake

    task automatic t_reset();
        rd_chk(`SCM_OFS_CONTROL_REG_ZERO, 32'h0);
        rd_chk(`SCM_OFS_CONTROL_REG_TWO, 32'h1);
        rd_chk(`SCM_OFS_STATUS, 32'h0);
        rd_chk(`SCM_OFS_MODE, 32'h14);
        apb(1'b1, `SCM_OFS_STATUS, 32'h3);
        rd_chk(`SCM_OFS_STATUS, 32'h0);
        rd_chk(12'h010, 32'h0);
        check(err, 1'b1);
        check(ircFreqSel, `SCM_IRC_12MHZ);
        check(sharedPinsGpio, 1'b1);
        check({fastOscEn, slowXtalRun}, 2'h3);
        check(slowRcRun, 1'b1);
        $display("reset test done");
    endtask : t_reset

    task automatic t_slow();
        apb(1'b1, `SCM_OFS_CONTROL_REG_ZERO, 32'h1);
        wait_gate(1'b0, 1'b1);
        check(fastOscEn, 1'b0);
        rd_chk(`SCM_OFS_MODE, 32'h19);
        apb(1'b1, `SCM_OFS_CONTROL_REG_ZERO, 32'h3);
        repeat (2) @(negedge clk);
        check(slowXtalLowPower, 1'b1);
        check(slowXtalRun, 1'b1);
        rd_chk(`SCM_OFS_CONTROL_REG_ZERO, 32'h3);
        $display("slow test done");
    endtask : t_slow

    // Halt taken from Slow mode with keep-on set
    task automatic t_idle();
        halt();
        check({cpuHold, fastOscEn}, 2'h2);
        check({slowXtalRun, periphSlowClkOk}, 2'h3);
        check({wdtRun, powerDownFlag}, 2'h3);
        check(clrSeen, 1'b0);
        wait_gate(1'b0, 1'b0);
        rd_chk(`SCM_OFS_MODE, 32'h12);
        wake();
        check({cpuHold, fastOscEn}, 2'h0);
        apb(1'b1, `SCM_OFS_CONTROL_REG_ZERO, 32'h0);
        wait_gate(1'b1, 1'b0);
        check(slowXtalLowPower, 1'b0);
        $display("idle test done");
    endtask : t_idle

    task automatic t_sleep();
        @(posedge clk) wdtTimeout <= 1'b1;
        @(posedge clk) wdtTimeout <= 1'b0;
        rd_chk(`SCM_OFS_STATUS, 32'h3);
        @(posedge clk) clrWdtReq <= 1'b1;
        @(posedge clk) clrWdtReq <= 1'b0;
        rd_chk(`SCM_OFS_STATUS, 32'h2);
        apb(1'b1, `SCM_OFS_CONTROL_REG_TWO, 32'h0);
        halt();
        check({slowXtalRun, periphSlowClkOk}, 2'h0);
        check(cpuHold, 1'b1);
        check(clrSeen, 1'b1);
        check({watchdogExpiredFlag, powerDownFlag}, 2'h1);
        wait_gate(1'b0, 1'b0);
        rd_chk(`SCM_OFS_MODE, 32'h03);
        rd_chk(`SCM_OFS_CONTROL_REG_TWO, 32'h0);
        wake();
        check({cpuHold, fastOscEn}, 2'h1);
        wait_gate(1'b1, 1'b0);
        $display("sleep test done");
    endtask : t_sleep

    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        t_reset();
        t_slow();
        t_idle();
        t_sleep();
        close_out();
    end
endmodule : system_clock_mode_control_test

`default_nettype wire
